// >>> tsm_params.svh
// Constants shared by the transition smoother design files.
`ifndef TSM_PARAMS_SVH
`define TSM_PARAMS_SVH
// Durations in nanoseconds; samples = ns * kHz / TSM_NS_KHZ_DIV.
`define TSM_NS_KHZ_DIV 40'h00000f4240
`define TSM_DLTP_NS 32'h0003d090
`define TSM_DELTA_NB_NS 32'h001312d0
`define TSM_DELTA_NS 32'h00234934
`define TSM_FRAME_NS 32'h01312d00
`define TSM_OVL_NS 32'h001312d0
`define TSM_NB_KHZ 8'h08
`define TSM_LPC_ORDER 16
`define TSM_ZIR_LEN 16'h0040
`define TSM_ZIR_LOG2 6
`define TSM_Q15 15
`define TSM_LPC_Q 12
`define TSM_FRAC 8
`define TSM_FIFO_DEPTH 8
`endif

// >>> tsm_pkg.sv
// Types shared by the transition smoother design files.
package tsm_pkg;
    typedef enum logic [2:0] {TSM_NONE, TSM_MC1, TSM_MC2, TSM_MC3, TSM_C2T} tsm_case_e;
    typedef enum logic [1:0] {TSM_CELP, TSM_TCX, TSM_HQ} tsm_mode_e;
    typedef enum logic [1:0] {ST_IDLE, ST_PRIME, ST_ZIR, ST_RUN} tsm_state_e;
    typedef struct packed {
        tsm_case_e case_sel;
        tsm_mode_e prev_mode;
        tsm_mode_e cur_mode;
        logic mc3_extrap;
        logic [7:0] out_khz;
        logic [7:0] celp_khz;
    } tsm_cfg_s;
    typedef struct packed {
        logic lane;
        logic signed [15:0] a;
        logic signed [15:0] b;
        logic signed [15:0] c;
        logic signed [15:0] wa;
        logic signed [15:0] wb;
    } tsm_in_s;
    typedef struct packed {
        logic lane;
        logic signed [15:0] data;
    } tsm_out_s;
    typedef struct packed {
        logic mem_clear;
        logic load_defaults;
        logic force_tc;
        logic single_lpc;
        logic tcx_mem_update;
        logic mc3_extrap;
        logic dual_itx;
    } tsm_ctl_s;
endpackage

// >>> tsm_smoother.sv
// Coding-mode transition smoother: output FIFO and frame datapath.
// Behaviour
// [RQ1] Case one clears CELP state memories to zero.
// [RQ2] Case one loads fixed LPC and gain defaults.
// [RQ3] Case one forces transition coding mode.
// [RQ4] Case one uses end-of-frame LPC everywhere.
// [RQ5] Case one: first D samples previous synthesis, then overlap-add.
// [RQ6] No window compensation on previous transform signal.
// [RQ7] Case two: low-rate transform updates CELP memories.
// [RQ8] Case two: transform, linear cross-fade, then CELP.
// [RQ9] Cross-fade starts at quarter millisecond.
// [RQ10] Cross-fade ends 1.25 ms narrowband, else 2.3125 ms.
// [RQ11] Output frame is twenty milliseconds of samples.
// [RQ12] Case three resets or extrapolates, case-one smoothing.
// [RQ13] CELP-to-transform needs both rate inverse transforms.
// [RQ14] Overlap length is 1.25 ms at CELP rate.
// [RQ15] Modified CELP cancels aliasing inside overlap.
// [RQ16] Order-16 filter of previous last subframe.
// [RQ17] Filter state is decoded minus modified; never output.
// [RQ18] Zero-input recursion yields 64 samples.
// [RQ19] Response tapers linearly to zero.
// [RQ20] Add response to first 64 low-rate samples.
// [RQ21] Output rate uses linearly interpolated response.
// [RQ22] Bandwidth transition signal fills gap, then cross-fades.
// [RQ23] Zero-pad spectrum when output rate below CELP.
// [RQ24] Frame configuration latched at strobe, held all frame.
`include "tsm_params.svh"

// --------------------------------------------------------------------------
// Output FIFO
// --------------------------------------------------------------------------
module tsm_fifo #(
    parameter int W = 17,
    parameter int DEPTH = `TSM_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Fill side
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic room2,
    // Drain side
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0] cnt_q, cnt_d;
    logic ov_q, ov_d;
    logic [W-1:0] od_q, od_d;
    logic push, pop;

    // The head word sits in its own register so the drain side sees flops only.
    always_comb begin
        push = in_valid && in_ready;
        pop = (cnt_q != '0) && (!ov_q || out_ready);
        wp_d = push ? wp_q + 1'b1 : wp_q;
        rp_d = pop ? rp_q + 1'b1 : rp_q;
        cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        ov_d = pop ? 1'b1 : (out_ready ? 1'b0 : ov_q);
        od_d = pop ? mem[rp_q] : od_q;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            ov_q <= 1'b0;
            od_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
            ov_q <= ov_d;
            od_q <= od_d;
        end
        if (push) begin
            mem[wp_q] <= in_data;
        end
    end

    assign in_ready = cnt_q < (AW+1)'(DEPTH);
    assign room2 = cnt_d <= (AW+1)'(DEPTH - 2);
    assign out_valid = ov_q;
    assign out_data = od_q;
endmodule

// --------------------------------------------------------------------------
// Transition smoother top
// --------------------------------------------------------------------------
module tsm_smoother #(
    parameter int DELAY_D = 16,
    parameter int ALIAS_LEN = 16,
    parameter int GAP_LEN = 16,
    parameter int XF_LOG2 = 4,
    parameter int FIFO_DEPTH = `TSM_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Frame control
    input wire logic frame_start,
    input tsm_pkg::tsm_cfg_s frame_cfg,
    input wire logic [`TSM_LPC_ORDER*16-1:0] lpc_coef,
    // Sample input
    input wire logic in_valid,
    input tsm_pkg::tsm_in_s in_data,
    output logic in_ready,
    // Sample output
    output logic out_valid,
    output tsm_pkg::tsm_out_s out_data,
    input wire logic out_ready,
    // Decoder control
    output tsm_pkg::tsm_ctl_s ctl,
    output logic [15:0] pad_len,
    output logic busy
);
    localparam int M = `TSM_LPC_ORDER;

    function automatic logic signed [39:0] ext(input logic signed [15:0] x);
        return {{24{x[15]}}, x};
    endfunction

    function automatic logic signed [15:0] sat16(input logic signed [39:0] v);
        if (v > 40'sh0000007fff) begin
            return 16'sh7fff;
        end else if (v < -40'sh0000008000) begin
            return -16'sh8000;
        end
        return v[15:0];
    endfunction

    function automatic logic signed [39:0] mulq15(input logic signed [15:0] x, input logic signed [15:0] w);
        return (ext(x) * ext(w)) >>> `TSM_Q15;
    endfunction

    function automatic logic [15:0] smp(input logic [31:0] ns, input logic [7:0] khz);
        logic [39:0] p;
        p = ({8'h00, ns} * {32'h00000000, khz}) / `TSM_NS_KHZ_DIV;
        return p[15:0];
    endfunction

    // ----------------------------------------------------------------------
    // State
    // ----------------------------------------------------------------------
    tsm_pkg::tsm_state_e state_q, state_d;
    tsm_pkg::tsm_cfg_s cfg_q, cfg_d;
    tsm_pkg::tsm_ctl_s ctl_q, ctl_d;
    logic signed [15:0] lpc_q [M];
    logic signed [15:0] lpc_d [M];
    logic signed [15:0] hist_q [M];
    logic signed [15:0] hist_d [M];
    logic signed [15:0] zir_q [`TSM_ZIR_LEN];
    logic signed [15:0] zir_d [`TSM_ZIR_LEN];
    logic [15:0] nc_q, nc_d, no_q, no_d, prime_q, prime_d;
    logic [15:0] dltp_q, dltp_d, delta_q, delta_d, nout_q, nout_d, nt_q, nt_d, step_q, step_d;
    logic [15:0] pad_q, pad_d;
    logic [3:0] tap_q, tap_d;
    logic [5:0] zn_q, zn_d;
    logic signed [39:0] acc_q, acc_d;
    logic in_ready_q, in_ready_d;
    logic busy_q, busy_d;

    logic accept, push, fifo_in_ready, fifo_room2;
    tsm_pkg::tsm_out_s fifo_din;
    logic [15:0] n, k, den, lfull, lcelp;
    logic [31:0] pos;
    logic signed [39:0] y, num, prod, z0, z1, hat;
    logic signed [15:0] yz, t1, t2, diff;

    // ----------------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        cfg_d = cfg_q;
        ctl_d = ctl_q;
        lpc_d = lpc_q;
        hist_d = hist_q;
        zir_d = zir_q;
        nc_d = nc_q;
        no_d = no_q;
        prime_d = prime_q;
        dltp_d = dltp_q;
        delta_d = delta_q;
        nout_d = nout_q;
        nt_d = nt_q;
        step_d = step_q;
        pad_d = pad_q;
        tap_d = tap_q;
        zn_d = zn_q;
        acc_d = acc_q;
        busy_d = busy_q;
        lfull = '0;
        lcelp = '0;
        n = in_data.lane ? no_q : nc_q;
        k = n - 16'(GAP_LEN);
        den = (delta_q > dltp_q) ? delta_q - dltp_q : 16'h0001;
        pos = 32'(n) * 32'(step_q);
        y = ext(in_data.a);
        num = '0;
        z0 = '0;
        z1 = '0;
        accept = in_valid && in_ready_q;
        // Aliasing-cancelled CELP value and the filter-state difference.
        t1 = sat16(mulq15(in_data.a, in_data.wa));
        t2 = sat16(mulq15(in_data.b, in_data.wb));
        hat = ext(in_data.c) + mulq15(t1, in_data.wa) + mulq15(t2, in_data.wa); // RQ15
        diff = sat16(ext(in_data.a) - hat); // RQ17
        prod = ext(lpc_q[tap_q]) * ext(hist_q[tap_q]);
        yz = sat16(-((acc_q + prod) >>> `TSM_LPC_Q));

        case (cfg_q.case_sel)
            tsm_pkg::TSM_MC1, tsm_pkg::TSM_MC3: begin
                if (in_data.lane && n < 16'(DELAY_D)) begin
                    y = ext(in_data.b); // RQ5 RQ12
                end else if (in_data.lane && n < 16'(DELAY_D + ALIAS_LEN)) begin
                    y = ext(in_data.a) + ext(in_data.b); // RQ5 RQ6 RQ12
                end
            end
            tsm_pkg::TSM_MC2: begin
                if (!in_data.lane || n < dltp_q) begin
                    y = ext(in_data.b); // RQ7 RQ8
                end else if (n < delta_q) begin
                    num = ext(in_data.b) * ext(delta_q - n) + ext(in_data.a) * ext(n - dltp_q);
                    y = num / ext(den); // RQ8
                end
            end
            tsm_pkg::TSM_C2T: begin
                if (!in_data.lane) begin
                    if (n < `TSM_ZIR_LEN) begin
                        y = ext(in_data.a) + ext(zir_q[n[5:0]]); // RQ20
                    end
                end else begin
                    if (pos[31:`TSM_FRAC] < 24'(`TSM_ZIR_LEN)) begin
                        z0 = ext(zir_q[pos[`TSM_FRAC+5:`TSM_FRAC]]);
                        if (pos[31:`TSM_FRAC] < 24'(`TSM_ZIR_LEN - 16'h0001)) begin
                            z1 = ext(zir_q[pos[`TSM_FRAC+5:`TSM_FRAC] + 6'h01]);
                        end
                        y = y + z0 + (((z1 - z0) * ext({8'h00, pos[7:0]})) >>> `TSM_FRAC); // RQ21
                    end
                    if (n < 16'(GAP_LEN)) begin
                        y = y + ext(in_data.c); // RQ22
                    end else if (k < 16'(1 << XF_LOG2)) begin
                        y = y + ((ext(in_data.c) * ext(16'(1 << XF_LOG2) - k)) >>> XF_LOG2); // RQ22
                    end
                end
            end
            default: begin
                y = ext(in_data.a);
            end
        endcase
        push = accept && state_q == tsm_pkg::ST_RUN && fifo_in_ready;
        fifo_din.lane = in_data.lane;
        fifo_din.data = sat16(y);

        case (state_q)
            tsm_pkg::ST_PRIME: begin
                if (accept) begin
                    for (int i = M - 1; i > 0; i--) begin
                        hist_d[i] = hist_q[i-1];
                    end
                    hist_d[0] = diff; // RQ17
                    prime_d = prime_q + 16'h0001;
                    if (prime_d >= nt_q) begin
                        state_d = tsm_pkg::ST_ZIR; // RQ14
                    end
                end
            end
            tsm_pkg::ST_ZIR: begin
                acc_d = acc_q + prod; // RQ16
                tap_d = tap_q + 4'h1;
                if (tap_q == 4'(M - 1)) begin
                    acc_d = '0;
                    for (int i = M - 1; i > 0; i--) begin
                        hist_d[i] = hist_q[i-1];
                    end
                    hist_d[0] = yz; // RQ18
                    zir_d[zn_q] = sat16((ext(yz) * ext(`TSM_ZIR_LEN - {10'h000, zn_q})) >>> `TSM_ZIR_LOG2); // RQ19
                    zn_d = zn_q + 6'h01;
                    if (zn_q == 6'(`TSM_ZIR_LEN - 16'h0001)) begin
                        state_d = tsm_pkg::ST_RUN; // RQ18
                    end
                end
            end
            tsm_pkg::ST_RUN: begin
                if (push && in_data.lane && no_q < nout_q) begin
                    no_d = no_q + 16'h0001; // RQ11
                end
                if (push && !in_data.lane && nc_q != 16'hffff) begin
                    nc_d = nc_q + 16'h0001;
                end
            end
            default: begin
                state_d = state_q;
            end
        endcase

        // A frame strobe restarts state, counters and filter history, winning over work in flight; the FIFO and zir_q keep their contents.
        if (frame_start) begin
            cfg_d = frame_cfg; // RQ24
            busy_d = 1'b1;
            for (int i = 0; i < M; i++) begin
                lpc_d[i] = lpc_coef[i*16 +: 16]; // RQ16
                hist_d[i] = '0;
            end
            nc_d = '0;
            no_d = '0;
            prime_d = '0;
            tap_d = '0;
            zn_d = '0;
            acc_d = '0;
            dltp_d = smp(`TSM_DLTP_NS, frame_cfg.out_khz); // RQ9
            delta_d = smp((frame_cfg.out_khz == `TSM_NB_KHZ) ? `TSM_DELTA_NB_NS : `TSM_DELTA_NS,
                frame_cfg.out_khz); // RQ10
            nout_d = smp(`TSM_FRAME_NS, frame_cfg.out_khz); // RQ11
            nt_d = smp(`TSM_OVL_NS, frame_cfg.celp_khz); // RQ14
            step_d = 16'(({16'h0000, frame_cfg.celp_khz} << `TSM_FRAC) /
                ((frame_cfg.out_khz == 8'h00) ? 24'h000001 : {16'h0000, frame_cfg.out_khz}));
            lfull = nout_d;
            lcelp = smp(`TSM_FRAME_NS, frame_cfg.celp_khz);
            pad_d = (lfull < lcelp) ? lcelp - lfull : '0; // RQ23
            ctl_d.mem_clear = frame_cfg.case_sel == tsm_pkg::TSM_MC1 ||
                (frame_cfg.case_sel == tsm_pkg::TSM_MC3 && !frame_cfg.mc3_extrap); // RQ1 RQ12
            ctl_d.load_defaults = frame_cfg.case_sel == tsm_pkg::TSM_MC1; // RQ2
            ctl_d.force_tc = frame_cfg.case_sel == tsm_pkg::TSM_MC1; // RQ3
            ctl_d.single_lpc = frame_cfg.case_sel == tsm_pkg::TSM_MC1; // RQ4
            ctl_d.tcx_mem_update = frame_cfg.case_sel == tsm_pkg::TSM_MC2; // RQ7
            ctl_d.mc3_extrap = frame_cfg.case_sel == tsm_pkg::TSM_MC3 && frame_cfg.mc3_extrap; // RQ12
            ctl_d.dual_itx = frame_cfg.case_sel == tsm_pkg::TSM_C2T; // RQ13
            state_d = (frame_cfg.case_sel == tsm_pkg::TSM_C2T) ? tsm_pkg::ST_PRIME : tsm_pkg::ST_RUN;
        end
        // Ready looks one word ahead so an accepted sample always finds room.
        in_ready_d = !frame_start && fifo_room2 &&
            (state_d == tsm_pkg::ST_PRIME || state_d == tsm_pkg::ST_RUN);
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_q <= tsm_pkg::ST_IDLE;
            cfg_q <= '0;
            ctl_q <= '0;
            lpc_q <= '{default: '0};
            hist_q <= '{default: '0};
            zir_q <= '{default: '0};
            nc_q <= '0;
            no_q <= '0;
            prime_q <= '0;
            dltp_q <= '0;
            delta_q <= '0;
            nout_q <= '0;
            nt_q <= '0;
            step_q <= '0;
            pad_q <= '0;
            tap_q <= '0;
            zn_q <= '0;
            acc_q <= '0;
            in_ready_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cfg_q <= cfg_d;
            ctl_q <= ctl_d;
            lpc_q <= lpc_d;
            hist_q <= hist_d;
            zir_q <= zir_d;
            nc_q <= nc_d;
            no_q <= no_d;
            prime_q <= prime_d;
            dltp_q <= dltp_d;
            delta_q <= delta_d;
            nout_q <= nout_d;
            nt_q <= nt_d;
            step_q <= step_d;
            pad_q <= pad_d;
            tap_q <= tap_d;
            zn_q <= zn_d;
            acc_q <= acc_d;
            in_ready_q <= in_ready_d;
            busy_q <= busy_d;
        end
    end

    tsm_fifo #(.W($bits(tsm_pkg::tsm_out_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .srst(srst),
        .in_valid(push),
        .in_data(fifo_din),
        .in_ready(fifo_in_ready),
        .room2(fifo_room2),
        .out_valid(out_valid),
        .out_data(out_data),
        .out_ready(out_ready)
    );

    assign in_ready = in_ready_q;
    assign ctl = ctl_q;
    assign pad_len = pad_q;
    assign busy = busy_q;

    // ----------------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);

    chk_mc1_clear: assert property ( // RQ1
        frame_start && frame_cfg.case_sel == tsm_pkg::TSM_MC1 |=> ctl_q.mem_clear && ctl_q.load_defaults)
        else $error("case one did not clear memories");
    chk_mc1_tcmode: assert property ( // RQ3
        frame_start && frame_cfg.case_sel == tsm_pkg::TSM_MC1 |=> ctl_q.force_tc && ctl_q.single_lpc)
        else $error("case one did not force transition coding");
    chk_mc2_update: assert property ( // RQ7
        frame_start && frame_cfg.case_sel == tsm_pkg::TSM_MC2 |=> ctl_q.tcx_mem_update && !ctl_q.mem_clear)
        else $error("case two memory update wrong");
    chk_cfg_hold: assert property ( // RQ24
        !frame_start |=> $stable(cfg_q) && $stable(ctl_q))
        else $error("frame configuration changed inside frame");
    chk_mc1_head: assert property ( // RQ5
        push && cfg_q.case_sel == tsm_pkg::TSM_MC1 && in_data.lane && no_q < 16'(DELAY_D)
        |-> fifo_din.data == in_data.b)
        else $error("head samples not replaced by previous synthesis");
    chk_mc2_head: assert property ( // RQ8
        push && cfg_q.case_sel == tsm_pkg::TSM_MC2 && in_data.lane && no_q < dltp_q |-> fifo_din.data == in_data.b)
        else $error("cross-fade started too early");
    chk_zir_tail: assert property ( // RQ20
        push && cfg_q.case_sel == tsm_pkg::TSM_C2T && !in_data.lane && nc_q >= `TSM_ZIR_LEN
        |-> fifo_din.data == in_data.a)
        else $error("response added beyond its length");
    chk_prime_quiet: assert property ( // RQ17
        state_q == tsm_pkg::ST_PRIME || state_q == tsm_pkg::ST_ZIR |-> !push)
        else $error("modified signal leaked to output");
    chk_zir_end: assert property ( // RQ18
        state_q == tsm_pkg::ST_ZIR && zn_q == 6'h3f && tap_q == 4'hf && !frame_start |=> state_q == tsm_pkg::ST_RUN)
        else $error("response not finished after 64 samples");
    chk_pad_none: assert property ( // RQ23
        frame_start && frame_cfg.out_khz >= frame_cfg.celp_khz |=> pad_q == '0)
        else $error("padding requested without need");
endmodule

// >>> tsm_src.sv
// Behavioural decoder-core source feeding samples into the smoother.
module tsm_src (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Bench control
    input wire logic go,
    input wire logic quiet,
    // Sample stream
    output logic in_valid,
    output tsm_pkg::tsm_in_s in_data,
    input wire logic in_ready
);
    timeunit 1ns;
    timeprecision 1ps;

    function automatic logic [15:0] rnd();
        return 16'($urandom_range(8000)) - 16'h0fa0;
    endfunction

    initial begin
        in_valid = 1'b0;
        in_data = '0;
    end

    // A word is held until taken; afterwards the lines show inverted data so stale words never pass.
    always @(posedge ref_clk) begin
        if (srst) begin
            in_valid <= 1'b0;
        end else if (in_valid && in_ready) begin
            in_valid <= 1'b0;
            in_data <= ~in_data;
        end else if (!in_valid && go && $urandom_range(3) != 0) begin
            in_valid <= 1'b1;
            in_data.lane <= 1'($urandom_range(1));
            in_data.a <= rnd();
            in_data.b <= quiet ? 16'h0000 : rnd();
            in_data.c <= quiet ? 16'h0000 : rnd();
            in_data.wa <= quiet ? 16'h0000 : 16'($urandom_range(32767));
            in_data.wb <= quiet ? 16'h0000 : 16'($urandom_range(32767));
        end
    end
endmodule

// >>> tb.sv
// Self-checking bench for the transition smoother with a queue-based reference.
`include "tsm_params.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic frame_start = 1'b0;
    tsm_pkg::tsm_cfg_s frame_cfg = '0;
    logic [`TSM_LPC_ORDER*16-1:0] lpc_coef = '0;
    logic in_valid, in_ready, out_valid, busy;
    logic out_ready = 1'b0;
    logic go = 1'b0;
    logic quiet = 1'b0;
    logic stall = 1'b0;
    tsm_pkg::tsm_in_s in_data;
    tsm_pkg::tsm_out_s out_data;
    tsm_pkg::tsm_ctl_s ctl;
    logic [15:0] pad_len;
    int err_count = 0;
    int num_checks = 0;
    int cnt[2];
    int acc, nt, dltp, delta, zlast, st;
    logic [16:0] expq[$];

    tsm_smoother tsm_smoother_i (.ref_clk, .srst, .frame_start, .frame_cfg, .lpc_coef, .in_valid,
        .in_data, .in_ready, .out_valid, .out_data, .out_ready, .ctl, .pad_len, .busy);
    tsm_src tsm_src_i (.ref_clk, .srst, .go, .quiet, .in_valid, .in_data, .in_ready);

    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) out_ready <= !stall && $urandom_range(3) != 0;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        if (err_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Clamp to the signed 16-bit output range.
    function automatic int sat(input int v);
        return v < -32768 ? -32768 : v > 32767 ? 32767 : v;
    endfunction

    // Filter-state sample: decoded CELP minus the aliasing-cancelled CELP value, weights in Q15.
    function automatic int diffq(input logic signed [15:0] a, b, c, wa, wb);
        int h;
        h = c + ((sat((int'(a) * wa) >>> 15) * wa) >>> 15) + ((sat((int'(b) * wb) >>> 15) * wa) >>> 15);
        return sat(a - h);
    endfunction

    // Tapered response; positions past the last sample contribute nothing.
    function automatic int zt(input int i);
        return i < 64 ? (zlast * (64 - i)) >>> 6 : 0;
    endfunction

    // Reference output for one run-phase sample; the per-lane count advances here.
    function automatic logic [16:0] model(input logic ln, input logic signed [15:0] a, b, c);
        int n, k, v, i;
        n = cnt[ln];
        k = n - 16;
        i = n * st;
        v = a;
        if (frame_cfg.case_sel inside {tsm_pkg::TSM_MC1, tsm_pkg::TSM_MC3} && ln) begin
            v = n < 16 ? b : n < 32 ? a + b : a;
        end else if (frame_cfg.case_sel == tsm_pkg::TSM_MC2) begin
            v = !ln || n < dltp ? b : n < delta ? (b * (delta - n) + a * (n - dltp)) / (delta - dltp) : a;
        end else if (frame_cfg.case_sel == tsm_pkg::TSM_C2T) begin
            if (!ln && n < 64) v = a + zt(n);
            if (ln && i < 64 * 256) v = a + zt(i >> 8) +
                (((zt((i >> 8) + 1) - zt(i >> 8)) * (i & 255)) >>> 8);
            if (ln) v += k < 0 ? c : k < 16 ? (c * (16 - k)) >>> 4 : 0;
        end
        cnt[ln]++;
        return {ln, 16'(sat(v))};
    endfunction

    always @(posedge ref_clk) begin
        if (!srst && in_valid && in_ready && !frame_start) begin
            if (acc < nt) zlast = diffq(in_data.a, in_data.b, in_data.c, in_data.wa, in_data.wb);
            else expq.push_back(model(in_data.lane, in_data.a, in_data.b, in_data.c));
            acc++;
        end
        if (!srst && out_valid && out_ready) begin
            check(32'(expq.size() != 0), 32'h1);
            if (expq.size() != 0) check(32'(out_data), 32'(expq.pop_front()));
        end
    end

    function automatic tsm_pkg::tsm_cfg_s mk(tsm_pkg::tsm_case_e cs, logic ex, logic [7:0] ok, logic [7:0] ck);
        return '{case_sel: cs, prev_mode: tsm_pkg::TSM_TCX, cur_mode: tsm_pkg::TSM_CELP, mc3_extrap: ex,
            out_khz: ok, celp_khz: ck};
    endfunction

    task automatic run_frame(input tsm_pkg::tsm_cfg_s cfg, input int ns, input logic twice, input logic hold);
        int g;
        int o;
        go <= 1'b0;
        g = 0;
        do @(negedge ref_clk); while ((in_valid || expq.size() != 0) && ++g < 3000);
        check(32'(expq.size()), 32'h0);
        o = cfg.out_khz;
        @(posedge ref_clk);
        if (twice) begin
            frame_start <= 1'b1;
            @(posedge ref_clk);
        end
        frame_cfg <= cfg;
        frame_start <= 1'b1;
        @(posedge ref_clk);
        frame_start <= 1'b0;
        cnt = '{0, 0};
        acc = 0;
        nt = cfg.case_sel == tsm_pkg::TSM_C2T ? cfg.celp_khz * 125 / 100 : 0;
        dltp = o * 250 / 1000;
        delta = o == 8 ? o * 1250 / 1000 : o * 23125 / 10000;
        st = cfg.celp_khz * 256 / o;
        quiet <= cfg.case_sel == tsm_pkg::TSM_NONE;
        @(negedge ref_clk);
        if (cfg.case_sel == tsm_pkg::TSM_MC3) check({ctl.mem_clear, ctl.mc3_extrap}, {!cfg.mc3_extrap, cfg.mc3_extrap});
        else check(ctl, cfg.case_sel == tsm_pkg::TSM_MC1 ? 7'h78 : cfg.case_sel == tsm_pkg::TSM_MC2 ? 7'h04 :
            cfg.case_sel == tsm_pkg::TSM_C2T ? 7'h01 : 7'h00);
        check(pad_len, o < cfg.celp_khz ? 20 * (cfg.celp_khz - o) : 0);
        check(busy, 1'b1);
        go <= 1'b1;
        if (hold) begin
            repeat (20) @(negedge ref_clk);
            stall <= 1'b1;
            repeat (40) @(negedge ref_clk);
            stall <= 1'b0;
        end
        g = 0;
        do @(negedge ref_clk); while (acc < nt && ++g < 3000);
        do @(negedge ref_clk); while (acc < nt + ns && ++g < 9000);
        check(32'(acc >= nt + ns), 32'h1);
    endtask

    initial begin
        repeat (40000) @(posedge ref_clk);
        err_count++;
        test_done();
    end

    initial begin
        void'($urandom(32'h26b3768a));
        repeat (8) @(posedge ref_clk);
        srst <= 1'b0;
        run_frame(mk(tsm_pkg::TSM_NONE, 1'b0, 8'h10, 8'h10), 60, 1'b0, 1'b0);
        run_frame(mk(tsm_pkg::TSM_MC1, 1'b0, 8'h10, 8'h10), 100, 1'b1, 1'b0);
        run_frame(mk(tsm_pkg::TSM_MC2, 1'b0, 8'h08, 8'h10), 100, 1'b0, 1'b1);
        run_frame(mk(tsm_pkg::TSM_MC2, 1'b0, 8'h20, 8'h10), 200, 1'b0, 1'b0);
        run_frame(mk(tsm_pkg::TSM_MC3, 1'b0, 8'h10, 8'h10), 100, 1'b0, 1'b0);
        run_frame(mk(tsm_pkg::TSM_MC3, 1'b1, 8'h10, 8'h10), 100, 1'b0, 1'b0);
        // Taking a1 as minus one makes the zero-input response repeat the last primed sample.
        @(posedge ref_clk);
        lpc_coef <= {240'h0, 16'hf000};
        run_frame(mk(tsm_pkg::TSM_C2T, 1'b0, 8'h20, 8'h10), 200, 1'b0, 1'b0);
        run_frame(mk(tsm_pkg::TSM_NONE, 1'b0, 8'h10, 8'h10), 4, 1'b0, 1'b0);
        go <= 1'b0;
        repeat (300) @(negedge ref_clk);
        check(32'(expq.size()), 32'h0);
        test_done();
    end
endmodule
